// ---- rtl/pto_pkg.sv ----
// Constants, register map and field layout of the trigger output unit
// Assumes an APB master on the same clock and a free-running system time
// ****************************************************************
// Contract
// - Each unit keeps a 30-bit target ns value, reset zero, top bits zero.
// - Each unit keeps a 32-bit target seconds value, reset zero.
// - Target and control accesses go to the unit a 2-bit index picks.
// - Bit 31 puts a unit into a cascade chain, else it runs alone.
// - Bit 30 marks a unit as the tail of the chain; the logic stores it but never reads it, so every chain loops.
// - With no tail in a chain the count is ignored and it loops forever.
// - A cascade unit starts on the done of the unit chosen by bits 27:26.
// - Bit 25 fires at once on a passed target, else a passed target sets the error and stops the unit.
// - Bit 24 enables done and error status and the interrupt.
// - Bit 23 high drives the output from the falling-edge copy, one clock later, low from the next level; both launch on the rising edge.
// - The enable self-clears on firing; software enables only the head.
// - Soft reset returns the unit to idle and defaults and stops a loop.
// - A 3-bit pattern field in bits 22:20 selects the output shape.
// - A read-only flag is one while the unit is enabled or out of idle.
// ****************************************************************
package pto_pkg;
   localparam int NUM_UNITS = 4;
   localparam logic [11:0] ADDR_STATUS = 12'h52c;
   localparam logic [11:0] ADDR_TGT_NS = 12'h530;
   localparam logic [11:0] ADDR_TGT_S = 12'h534;
   localparam logic [11:0] ADDR_CTRL1 = 12'h538;
   localparam logic [11:0] ADDR_INDEX = 12'h540;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h544;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h548;
   localparam logic [11:0] ADDR_SYS_NS = 12'h54c;
   localparam logic [11:0] ADDR_SYS_S = 12'h550;
   localparam int NS_W = 30;
   localparam logic [29:0] NS_PER_S = 30'h3b9ac9ff;
   localparam int B_CHAIN = 31;
   localparam int B_TAIL = 30;
   localparam int B_UP_HI = 27;
   localparam int B_UP_LO = 26;
   localparam int B_NOW = 25;
   localparam int B_NOTIFY = 24;
   localparam int B_EDGE = 23;
   localparam int B_PAT_HI = 22;
   localparam int B_PAT_LO = 20;
   localparam logic [31:0] CTRL1_MASK = 32'hcff00000;
   localparam int B_ACTIVE = 4;
   localparam int B_ENABLE = 3;
   localparam int B_SWRST = 2;
   localparam logic [2:0] PAT_FALL = 3'h0;
   localparam logic [2:0] PAT_RISE = 3'h1;
   localparam logic [2:0] PAT_LOPULSE = 3'h2;
   localparam logic [2:0] PAT_HIPULSE = 3'h3;
   localparam logic [2:0] PAT_LOPER = 3'h4;
   localparam logic [2:0] PAT_HIPER = 3'h5;
   localparam logic [31:0] ZERO32 = 32'h0;
   // Per-unit state, no codes given
   typedef enum logic [1:0] {PTO_IDLE, PTO_ARMED, PTO_PULSE} pto_state_t;
endpackage

// ---- rtl/pto_trigger_unit.sv ----
// Four indexed PTP trigger output units behind an APB slave
// Assumes APB on CORE_CLK, system time counting in the same domain
`timescale 1ns/1ns
module pto_trigger_unit
   import pto_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic [3:0] TRIG_OUT,
   output logic IRQ
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [1:0] index_reg, index_next;
   logic [29:0] sys_ns_reg, sys_ns_next;
   logic [31:0] sys_s_reg, sys_s_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [3:0] irq_stat_reg, irq_stat_next;
   logic [3:0] irq_mask_reg, irq_mask_next;
   logic irq_reg, irq_next;
   logic [29:0] tns_reg [NUM_UNITS];
   logic [29:0] tns_next [NUM_UNITS];
   logic [31:0] ts_reg [NUM_UNITS];
   logic [31:0] ts_next [NUM_UNITS];
   logic [31:0] ctl_reg [NUM_UNITS];
   logic [31:0] ctl_next [NUM_UNITS];
   logic [3:0] en_reg, en_next;
   logic [3:0] err_reg, err_next;
   logic [3:0] lvl_reg, lvl_next;
   logic [3:0] fneg_reg;
   logic [3:0] done_reg, done_next;
   logic [3:0] out_reg;
   pto_state_t st_reg [NUM_UNITS];
   pto_state_t st_next [NUM_UNITS];
   logic acc, wr, rd;
   logic [3:0] swrst, reached, fire, done_ev;

   // APB access taken once; PREADY follows one cycle later
   assign acc = PSEL && PENABLE && !pready_reg;
   assign wr = acc && PWRITE;
   assign rd = acc && !PWRITE;

   // ****************************************************************
   // System time and global registers
   // ****************************************************************
   always_comb begin
      sys_ns_next = sys_ns_reg + 30'h1;
      sys_s_next = sys_s_reg;
      if (sys_ns_reg == NS_PER_S) begin
         sys_ns_next = '0;
         sys_s_next = sys_s_reg + 32'h1;
      end
      if (wr && PADDR == ADDR_SYS_NS) begin
         sys_ns_next = PWDATA[NS_W-1:0];
      end
      if (wr && PADDR == ADDR_SYS_S) begin
         sys_s_next = PWDATA;
      end
      index_next = index_reg;
      if (wr && PADDR == ADDR_INDEX) begin
         index_next = PWDATA[1:0];
      end
      irq_mask_next = irq_mask_reg;
      if (wr && PADDR == ADDR_IRQ_MASK) begin
         irq_mask_next = PWDATA[3:0];
      end
      // Set wins over write-one-to-clear
      irq_stat_next = irq_stat_reg;
      if (wr && PADDR == ADDR_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~PWDATA[3:0];
      end
      irq_stat_next = irq_stat_next | done_ev;
      irq_next = |(irq_stat_reg & irq_mask_reg);
   end

   // ****************************************************************
   // Per-unit trigger logic
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_UNITS; g++) begin : g_unit
         logic sel;
         logic [31:0] c;
         logic [1:0] up;
         assign sel = index_reg == 2'(g);
         assign c = ctl_reg[g];
         assign up = c[B_UP_HI:B_UP_LO];
         assign swrst[g] = wr && sel && PADDR == ADDR_STATUS &&
            PWDATA[B_SWRST];
         // Target reached when system time is at or past it
         assign reached[g] = {sys_s_reg, sys_ns_reg} >=
            {ts_reg[g], tns_reg[g]};
         // Passed-target check with now bit, else wait for equal
         assign fire[g] = c[B_NOW] ? reached[g] :
            ({sys_s_reg, sys_ns_reg} == {ts_reg[g], tns_reg[g]});

         always_comb begin
            tns_next[g] = tns_reg[g];
            ts_next[g] = ts_reg[g];
            ctl_next[g] = ctl_reg[g];
            en_next[g] = en_reg[g];
            err_next[g] = err_reg[g];
            lvl_next[g] = lvl_reg[g];
            st_next[g] = st_reg[g];
            done_next[g] = 1'b0;
            if (wr && sel && PADDR == ADDR_TGT_NS) begin
               tns_next[g] = PWDATA[NS_W-1:0];
            end
            if (wr && sel && PADDR == ADDR_TGT_S) begin
               ts_next[g] = PWDATA;
            end
            if (wr && sel && PADDR == ADDR_CTRL1) begin
               ctl_next[g] = PWDATA & CTRL1_MASK;
            end
            if (wr && sel && PADDR == ADDR_STATUS) begin
               en_next[g] = PWDATA[B_ENABLE];
               if (PWDATA[B_ENABLE]) begin
                  err_next[g] = 1'b0;
               end
            end
            case (st_reg[g])
               PTO_IDLE: begin
                  // Arm on enable or upstream done, loading the idle level
                  if (en_reg[g] || c[B_CHAIN] && done_reg[up]) begin
                     lvl_next[g] = (c[B_PAT_HI:B_PAT_LO] == PAT_HIPULSE ||
                        c[B_PAT_HI:B_PAT_LO] == PAT_HIPER) ? 1'b0 :
                        1'b1;
                     st_next[g] = PTO_ARMED;
                  end
               end
               PTO_ARMED: begin
                  if (fire[g]) begin
                     case (c[B_PAT_HI:B_PAT_LO])
                        PAT_FALL, PAT_LOPULSE, PAT_LOPER: lvl_next[g] = 1'b0;
                        PAT_RISE, PAT_HIPULSE, PAT_HIPER: lvl_next[g] = 1'b1;
                        default: lvl_next[g] = lvl_reg[g];
                     endcase
                     en_next[g] = 1'b0;
                     st_next[g] = PTO_PULSE;
                  end else if (!c[B_NOW] && reached[g]) begin
                     // Target passed without now bit: error, stop
                     err_next[g] = 1'b1;
                     en_next[g] = 1'b0;
                     st_next[g] = PTO_IDLE;
                  end
               end
               PTO_PULSE: begin
                  // Pulses last one clock; edges hold their level
                  if (c[B_PAT_HI:B_PAT_LO] == PAT_LOPULSE ||
                      c[B_PAT_HI:B_PAT_LO] == PAT_HIPULSE) begin
                     lvl_next[g] = ~lvl_reg[g];
                  end
                  done_next[g] = 1'b1;
                  // Tail-less chains loop; re-arm from upstream done
                  st_next[g] = PTO_IDLE;
               end
               default: st_next[g] = PTO_IDLE;
            endcase
            // Soft reset restores defaults and breaks any loop
            if (swrst[g]) begin
               ctl_next[g] = ZERO32;
               en_next[g] = 1'b0;
               err_next[g] = 1'b0;
               lvl_next[g] = 1'b1;
               st_next[g] = PTO_IDLE;
            end
         end

         // Status event only when notify is set
         assign done_ev[g] = c[B_NOTIFY] &&
            (done_reg[g] || (err_next[g] && !err_reg[g]));

         always_ff @(posedge CORE_CLK) begin
            if (RESET) begin
               tns_reg[g] <= '0;
               ts_reg[g] <= '0;
               ctl_reg[g] <= '0;
               en_reg[g] <= 1'b0;
               err_reg[g] <= 1'b0;
               lvl_reg[g] <= 1'b1;
               done_reg[g] <= 1'b0;
               st_reg[g] <= PTO_IDLE;
            end else begin
               tns_reg[g] <= tns_next[g];
               ts_reg[g] <= ts_next[g];
               ctl_reg[g] <= ctl_next[g];
               en_reg[g] <= en_next[g];
               err_reg[g] <= err_next[g];
               lvl_reg[g] <= lvl_next[g];
               done_reg[g] <= done_next[g];
               st_reg[g] <= st_next[g];
            end
         end

         // Falling-edge copy of the level
         always_ff @(negedge CORE_CLK) begin
            if (RESET) begin
               fneg_reg[g] <= 1'b1;
            end else begin
               fneg_reg[g] <= lvl_reg[g];
            end
         end

         // Rising-edge output flop picks the falling-edge copy or the next level
         always_ff @(posedge CORE_CLK) begin
            if (RESET) begin
               out_reg[g] <= 1'b1;
            end else begin
               out_reg[g] <= c[B_EDGE] ? fneg_reg[g] : lvl_next[g];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // APB read mux
   // ****************************************************************
   always_comb begin
      prdata_next = prdata_reg;
      pready_next = acc;
      pslverr_next = 1'b0;
      if (rd) begin
         case (PADDR)
            ADDR_TGT_NS: prdata_next = {2'h0, tns_reg[index_reg]};
            ADDR_TGT_S: prdata_next = ts_reg[index_reg];
            ADDR_CTRL1: prdata_next = ctl_reg[index_reg];
            ADDR_STATUS: prdata_next = {27'h0,
               st_reg[index_reg] != PTO_IDLE || en_reg[index_reg],
               en_reg[index_reg], 3'h0};
            ADDR_INDEX: prdata_next = {30'h0, index_reg};
            ADDR_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
            ADDR_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
            ADDR_SYS_NS: prdata_next = {2'h0, sys_ns_reg};
            ADDR_SYS_S: prdata_next = sys_s_reg;
            default: begin
               prdata_next = ZERO32;
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   // Global register bank
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         index_reg <= '0;
         sys_ns_reg <= '0;
         sys_s_reg <= '0;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         index_reg <= index_next;
         sys_ns_reg <= sys_ns_next;
         sys_s_reg <= sys_s_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg <= irq_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign TRIG_OUT = out_reg;
   assign IRQ = irq_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_armed0;
      st_reg[0] == PTO_ARMED && fire[0];
   endsequence
   property p_selfclear;
      @(posedge CORE_CLK) disable iff (RESET)
      s_armed0 |=> !en_reg[0] ##1 st_reg[0] == PTO_IDLE;
   endproperty
   a_selfclear: assert property (p_selfclear)
      else $error("enable did not clear after fire");
   property p_ready;
      @(posedge CORE_CLK) disable iff (RESET)
      (PSEL && PENABLE && !PREADY) |=> PREADY;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb access not answered in one cycle");
   property p_notify;
      @(posedge CORE_CLK) disable iff (RESET)
      (done_reg[0] && !ctl_reg[0][B_NOTIFY] && !err_reg[0] &&
       !(wr && PADDR == ADDR_IRQ_STAT)) |=> $stable(irq_stat_reg[0]);
   endproperty
   a_notify: assert property (p_notify)
      else $error("status set without notify");
   property p_irq;
      @(posedge CORE_CLK) disable iff (RESET)
      |(irq_stat_reg & irq_mask_reg) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq not raised");
   property p_swrst;
      @(posedge CORE_CLK) disable iff (RESET)
      swrst[1] |=> st_reg[1] == PTO_IDLE && ctl_reg[1] == ZERO32 && !en_reg[1];
   endproperty
   a_swrst: assert property (p_swrst)
      else $error("soft reset left unit running");
   property p_early;
      @(posedge CORE_CLK) disable iff (RESET)
      (st_reg[0] == PTO_ARMED && !reached[0]) |=> st_reg[0] != PTO_PULSE;
   endproperty
   a_early: assert property (p_early)
      else $error("fired before target");
   property p_chain;
      @(posedge CORE_CLK) disable iff (RESET)
      (st_reg[1] == PTO_IDLE && ctl_reg[1][B_CHAIN] &&
       done_reg[ctl_reg[1][B_UP_HI:B_UP_LO]] &&
       !(wr && PADDR == ADDR_STATUS)) |=> st_reg[1] == PTO_ARMED;
   endproperty
   a_chain: assert property (p_chain)
      else $error("cascade unit did not start");
   property p_now;
      @(posedge CORE_CLK) disable iff (RESET)
      (st_reg[0] == PTO_ARMED && ctl_reg[0][B_NOW] && reached[0] &&
       !(wr && PADDR == ADDR_STATUS)) |=> st_reg[0] == PTO_PULSE;
   endproperty
   a_now: assert property (p_now)
      else $error("immediate trigger did not fire");
endmodule // pto_trigger_unit

// ---- sim/test_ptp_trigger_output_unit.sv ----
// Self-checking bench for the four-unit trigger output block
// Assumes the design answers APB with one wait state, registered outputs
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_ptp_trigger_output_unit;
   import pto_pkg::*;
   // ********************************
   // Signals and instance
   // ********************************
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [3:0] TRIG_OUT;
   logic IRQ;
   int failures = 0;
   int n_tests = 0;
   logic [31:0] q;
   logic e;

   pto_trigger_unit DUT (.CORE_CLK(core_clk), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .TRIG_OUT(TRIG_OUT), .IRQ(IRQ));

   // Free-running 100 MHz clock
   always #5 core_clk = ~core_clk;
   // ********************************
   // Bus and helper tasks
   // ********************************
   // One APB transfer, held until PREADY is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rq, output logic re);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      rq = PRDATA;
      re = PSLVERR;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rq;
      logic re;
      apb(1'b1, a, d, rq, re);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // Synchronous reset held for four cycles
   task automatic do_reset();
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
   endtask
   // Bounded wait for one trigger line to reach a level
   task automatic wait_out(input int u, input logic v, input int lim);
      int n;
      n = 0;
      while (TRIG_OUT[u] !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   // Index a unit and load its target and control words
   task automatic setup(input int u, input logic [31:0] s,
      input logic [31:0] ns, input logic [31:0] c);
      wr(ADDR_INDEX, u);
      wr(ADDR_TGT_NS, ns);
      wr(ADDR_TGT_S, s);
      wr(ADDR_CTRL1, c);
   endtask
   // ********************************
   // Scenarios
   // ********************************
   // Reset values of targets and outputs
   task automatic t_reset_vals();
      do_reset();
      rd(ADDR_TGT_NS);
      `CHK(q, ZERO32)
      rd(ADDR_TGT_S);
      `CHK(q, ZERO32)
      `CHK(TRIG_OUT, 4'hf)
      `CHK(IRQ, 1'b0)
      $display("test reset values done");
   endtask
   // Field widths, per-unit routing, patterns and an unmapped read
   task automatic t_regs();
      for (int u = 0; u < NUM_UNITS; u++) begin
         setup(u, 32'ha5a50000 | u, 32'hfffffff0 | u, 32'h0);
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
         wr(ADDR_INDEX, u);
         rd(ADDR_TGT_NS);
         `CHK(q, 32'h3ffffff0 | u)
         rd(ADDR_TGT_S);
         `CHK(q, 32'ha5a50000 | u)
      end
      wr(ADDR_CTRL1, 32'hffffffff);
      rd(ADDR_CTRL1);
      `CHK(q, CTRL1_MASK)
      for (int p = 0; p < 8; p++) begin
         wr(ADDR_CTRL1, p << B_PAT_LO);
         rd(ADDR_CTRL1);
         `CHK(q, p << B_PAT_LO)
      end
      rd(12'h5f0);
      `CHK(e, 1'b1)
      `CHK(q, ZERO32)
      $display("test registers done");
   endtask
   // Unit 0 waits for a future target, fires, self-clears, interrupts
   task automatic t_fire();
      do_reset();
      setup(0, 32'h1, 32'h190, 32'h1 << B_NOTIFY);
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_SYS_S, 32'h1);
      wr(ADDR_SYS_NS, 32'h0);
      wr(ADDR_STATUS, 32'h1 << B_ENABLE);
      rd(ADDR_STATUS);
      `CHK(q & 32'h18, 32'h18)
      `CHK(TRIG_OUT, 4'hf)
      wait_out(0, 1'b0, 3000);
      `CHK(TRIG_OUT, 4'he)
      repeat (3) @(posedge core_clk);
      rd(ADDR_STATUS);
      `CHK(q & 32'h18, ZERO32)
      rd(ADDR_IRQ_STAT);
      `CHK(q & 32'hf, 32'h1)
      `CHK(IRQ, 1'b1)
      wr(ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge core_clk);
      `CHK(IRQ, 1'b0)
      wr(ADDR_IRQ_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      `CHK(IRQ, 1'b1)
      wr(ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge core_clk);
      `CHK(IRQ, 1'b0)
      rd(ADDR_IRQ_STAT);
      `CHK(q & 32'hf, ZERO32)
      $display("test fire done");
   endtask
   // Passed target with and without the immediate bit, then soft reset
   task automatic t_passed();
      do_reset();
      wr(ADDR_SYS_S, 32'h5);
      setup(1, 32'h1, 32'h0, 32'h1 << B_NOW);
      wr(ADDR_STATUS, 32'h1 << B_ENABLE);
      wait_out(1, 1'b0, 20);
      `CHK(TRIG_OUT, 4'hd)
      setup(2, 32'h1, 32'h0, 32'h0);
      wr(ADDR_STATUS, 32'h1 << B_ENABLE);
      repeat (20) @(posedge core_clk);
      `CHK(TRIG_OUT, 4'hd)
      rd(ADDR_STATUS);
      `CHK(q & 32'h18, ZERO32)
      rd(ADDR_IRQ_STAT);
      `CHK(q & 32'hf, ZERO32)
      wr(ADDR_INDEX, 32'h1);
      wr(ADDR_STATUS, 32'h1 << B_SWRST);
      repeat (2) @(posedge core_clk);
      rd(ADDR_CTRL1);
      `CHK(q, ZERO32)
      `CHK(TRIG_OUT, 4'hf)
      $display("test passed target done");
   endtask
   // Units 0 and 1 loop as a tail-less chain, unit 1 output from the falling-edge copy
   task automatic t_cascade();
      logic [31:0] c1;
      do_reset();
      wr(ADDR_SYS_S, 32'h5);
      c1 = (32'h1 << B_CHAIN) | (32'h1 << B_NOW) | (32'h1 << B_EDGE) |
         (32'h1 << B_NOTIFY);
      setup(1, 32'h1, 32'h0, c1);
      setup(0, 32'h1, 32'h0,
         (32'h1 << B_CHAIN) | (32'h1 << B_NOW) | (32'h1 << B_UP_LO));
      repeat (10) @(posedge core_clk);
      `CHK(TRIG_OUT, 4'hf)
      wr(ADDR_STATUS, 32'h1 << B_ENABLE);
      wait_out(1, 1'b0, 30);
      `CHK(TRIG_OUT, 4'hc)
      // Unit 1 keeps reporting done while the loop runs
      wr(ADDR_IRQ_STAT, 32'h2);
      repeat (10) @(posedge core_clk);
      rd(ADDR_IRQ_STAT);
      `CHK(q & 32'hf, 32'h2)
      wr(ADDR_INDEX, 32'h1);
      wr(ADDR_STATUS, 32'h1 << B_SWRST);
      repeat (2) @(posedge core_clk);
      rd(ADDR_STATUS);
      `CHK(q & 32'h18, ZERO32)
      wr(ADDR_IRQ_STAT, 32'h2);
      repeat (10) @(posedge core_clk);
      rd(ADDR_IRQ_STAT);
      `CHK(q & 32'hf, ZERO32)
      $display("test cascade done");
   endtask
   // ********************************
   // Verdict and sequence
   // ********************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      t_reset_vals();
      t_regs();
      t_fire();
      t_passed();
      t_cascade();
      stop_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      #200000;
      failures++;
      stop_test();
   end
endmodule // test_ptp_trigger_output_unit
